// *** core/fkl_key_fsm.sv ***
// key sequencer: locked, first key, unlocked, dead until reset
// assumes key writes and flash operation strobes on the same clock
`default_nettype none

module fkl_key_fsm
	import fkl_pkg::*;
(
	input  wire logic       clk_i,       // system clock
	input  wire logic       arst_n_i,    // async reset, active low
	input  wire logic       key_wr_i,    // one-cycle key register write
	input  wire logic [7:0] key_data_i,  // value written
	input  wire logic       op_start_i,  // flash write or erase attempt
	input  wire logic       op_done_i,   // flash write or erase completed
	output logic      [1:0] status_o,    // lock status code
	output logic            unlocked_o   // flash writes allowed
);
	import fkl_pkg::*;

	fkl_state_t state;       // current key state
	fkl_state_t next_state;  // state for the next edge
	logic [1:0] next_status; // status code of next_state

	// op attempt while not open beats everything: it locks out for good
	always_comb
	begin
		next_state = state;
		case (state)
			FKL_LOCKED:
			begin
				if (op_start_i)
					next_state = FKL_DEAD;
				else if (key_wr_i)
					next_state = (key_data_i == FKL_KEY_FIRST) ?
						FKL_FIRST : FKL_DEAD;
			end
			FKL_FIRST:
			begin
				if (op_start_i)
					next_state = FKL_DEAD;
				else if (key_wr_i)
					next_state = (key_data_i == FKL_KEY_SECOND) ?
						FKL_OPEN : FKL_DEAD;
			end
			FKL_OPEN:
			begin
				// any key write while open is out of order
				if (key_wr_i)
					next_state = FKL_DEAD;
				else if (op_done_i)
					next_state = FKL_LOCKED;
			end
			FKL_DEAD:
				next_state = FKL_DEAD;
			default:
				next_state = FKL_DEAD; // corrupt code: fail safe
		endcase
	end

	// status encoding of the state the machine moves to
	assign next_status = (next_state == FKL_FIRST) ? FKL_ST_FIRST :
		(next_state == FKL_OPEN) ? FKL_ST_OPEN :
		(next_state == FKL_DEAD) ? FKL_ST_DEAD : FKL_ST_LOCKED;

	// state and registered outputs; reset clears the lockout
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state      <= FKL_LOCKED;
			status_o   <= FKL_ST_LOCKED;
			unlocked_o <= 1'b0;
		end
		else
		begin
			state      <= next_state;
			status_o   <= next_status;
			unlocked_o <= (next_state == FKL_OPEN);
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_first_key;
		state == FKL_LOCKED && key_wr_i && !op_start_i &&
			key_data_i == FKL_KEY_FIRST;
	endsequence
	sequence s_second_key;
		key_wr_i && !op_start_i && key_data_i == FKL_KEY_SECOND;
	endsequence

	a_key_pair_opens: assert property (
		s_first_key ##1 s_second_key |=> unlocked_o && status_o == 2'h2)
		else $error("correct key pair did not unlock");
	a_done_relocks: assert property (
		unlocked_o && op_done_i && !key_wr_i |=>
			!unlocked_o && status_o == 2'h0)
		else $error("completed operation did not relock");
	a_locked_op_dead: assert property (
		!unlocked_o && op_start_i |=> status_o == 2'h3 [*2])
		else $error("op attempt while locked did not lock out");
	a_bad_key_dead: assert property (
		status_o == 2'h0 && key_wr_i && !op_start_i &&
			key_data_i != 8'ha5 |=> status_o == 2'h3)
		else $error("wrong first key did not lock out");
	// the default disable would mute this check, so it opts out of it
	a_reset_locked: assert property (
		@(posedge clk_i) disable iff (1'b0)
			!arst_n_i |-> status_o == FKL_ST_LOCKED && !unlocked_o)
		else $error("reset did not return to locked");
endmodule

`default_nettype wire

// *** core/fkl_top.sv ***
// flash key lock control: key register, read timing select, dummy sink
// assumes a one-cycle strobe register port and flash strobes on clk_i
`default_nettype none

// Operation
// - unlock needs first key then second key
// - relock automatically after one write or erase
// - bad key or locked attempt locks until reset
// - key register read returns two-bit lock state
// - bypass clear: one-shot times flash reads
// - bypass set: system clock times flash reads
// - third fetch after bypass clear is suspect
// - dummy sink writes have no effect
module fkl_top
	import fkl_pkg::*;
(
	input  wire logic       clk_i,          // system clock
	input  wire logic       arst_n_i,       // async reset, active low
	input  wire logic [7:0] reg_addr_i,     // register address
	input  wire logic       reg_page_i,     // register page select
	input  wire logic [7:0] reg_wdata_i,    // write data
	input  wire logic       reg_wr_i,       // write strobe
	input  wire logic       reg_rd_i,       // read strobe
	output logic      [7:0] reg_rdata_o,    // read data, one cycle later
	input  wire logic       op_start_i,     // flash write/erase attempt
	input  wire logic       op_done_i,      // flash write/erase finished
	input  wire logic       fetch_i,        // one opcode byte fetched
	output logic            flash_wr_en_o,  // flash writes allowed
	output logic      [1:0] lock_status_o,  // current lock status code
	output logic            read_bypass_o,  // 1: clock times flash reads
	output logic            fetch_suspect_o // fetch now may be corrupt
);
	import fkl_pkg::*;

	// address decode shared by read and write paths
	function automatic logic reg_hit(input logic [7:0] addr,
		input logic page, input logic [7:0] ofs, input logic want_page,
		input logic use_page);
		reg_hit = (addr == ofs) && (!use_page || page == want_page);
	endfunction

	wire        key_sel;     // flash_key_lock selected
	wire        timing_sel;  // flash_read_timing selected
	wire        sink_sel;    // dummy_write_sink selected
	wire        key_wr;      // write to the key register
	wire        timing_wr;   // write to the timing register
	wire        bypass_clr;  // bypass going from set to clear
	wire [7:0]  next_rdata;  // read mux result
	wire [1:0]  key_status;  // status from the key sequencer
	wire        key_open;    // key sequencer unlocked
	logic [1:0] hz_cnt;      // fetches left until hazard window closes
	logic [1:0] next_hz;     // hazard count for the next edge

	assign key_sel    = reg_hit(reg_addr_i, reg_page_i, FKL_KEY_OFS,
		FKL_KEY_PAGE, 1'b1);
	assign timing_sel = reg_hit(reg_addr_i, reg_page_i, FKL_TIMING_OFS,
		FKL_TIMING_PAGE, 1'b1);
	// the sink answers on either page; writes land nowhere
	assign sink_sel   = reg_hit(reg_addr_i, reg_page_i, FKL_SINK_OFS,
		1'b0, 1'b0);
	assign key_wr     = reg_wr_i && key_sel;
	assign timing_wr  = reg_wr_i && timing_sel;
	// only bit 6 is kept; reserved bits are dropped, not stored
	assign bypass_clr = timing_wr && read_bypass_o &&
		!reg_wdata_i[FKL_BYPASS_BIT];

	// read mux: reserved bits, the sink and unmapped reads give zero
	assign next_rdata = key_sel ? {6'h00, key_status} :
		timing_sel ? {1'b0, read_bypass_o, 6'h00} :
		FKL_RDATA_RST;

	// key sequence and lockout live in their own machine
	fkl_key_fsm u_key
	(
		.clk_i      (clk_i),
		.arst_n_i   (arst_n_i),
		.key_wr_i   (key_wr),
		.key_data_i (reg_wdata_i),
		.op_start_i (op_start_i),
		.op_done_i  (op_done_i),
		.status_o   (key_status),
		.unlocked_o (key_open)
	);

	// hazard window: armed by a bypass clear, counted down by fetches
	always_comb
	begin
		next_hz = hz_cnt;
		if (bypass_clr)
			next_hz = FKL_HAZ_FETCHES;
		else if (fetch_i && hz_cnt != 2'h0)
			next_hz = hz_cnt - 2'h1;
	end

	// read data register, valid only the cycle after a read strobe
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			reg_rdata_o <= FKL_RDATA_RST;
		else if (reg_rd_i)
			reg_rdata_o <= next_rdata;
		else
			reg_rdata_o <= FKL_RDATA_RST;
	end

	// read timing select: one-shot when clear, system clock when set
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			read_bypass_o <= FKL_BYPASS_RST;
		else if (timing_wr)
			read_bypass_o <= reg_wdata_i[FKL_BYPASS_BIT];
	end

	// hazard counter and the flag marking the third fetch
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			hz_cnt          <= 2'h0;
			fetch_suspect_o <= 1'b0;
		end
		else
		begin
			hz_cnt          <= next_hz;
			fetch_suspect_o <= (next_hz == 2'h1);
		end
	end

	// re-register sequencer outputs so top outputs are local flops
	// (costs one cycle of latency on the status pins, not on reads)
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			flash_wr_en_o <= 1'b0;
			lock_status_o <= FKL_ST_LOCKED;
		end
		else
		begin
			flash_wr_en_o <= key_open;
			lock_status_o <= key_status;
		end
	end

	// checks below watch the register port, the pins and the hazard
	// window; all of them are off while reset is held, so the reset
	// values themselves are checked in the key sequencer and the bench
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	// key reads return the status the sequencer held at the strobe
	a_key_readback: assert property (
		reg_rd_i && key_sel |=> reg_rdata_o == {6'h00, $past(key_status)})
		else $error("key read did not return lock state");
	// a set selects system clock timing from the next cycle on
	a_bypass_follows: assert property (
		timing_wr && reg_wdata_i[6] |=> read_bypass_o)
		else $error("bypass set did not take effect");
	// a clear selects the one-shot next cycle and keeps it until a set
	a_oneshot_select: assert property (
		timing_wr && !reg_wdata_i[FKL_BYPASS_BIT] |=>
			!read_bypass_o ##1 (!read_bypass_o || $past(timing_wr)))
		else $error("bypass clear did not select one-shot");
	// the select only moves on a timing write
	a_bypass_holds: assert property (
		!timing_wr |=> $stable(read_bypass_o))
		else $error("read timing select moved without a write");

	// hazard: a clear that arms the window, then fetches counting it down
	sequence s_bypass_clear;
		bypass_clr;
	endsequence
	// a fetch that no new clear re-arms in the same cycle
	sequence s_plain_fetch;
		!bypass_clr && fetch_i;
	endsequence

	a_third_fetch: assert property (
		s_bypass_clear ##1 s_plain_fetch ##1 s_plain_fetch |=>
			fetch_suspect_o)
		else $error("third fetch after bypass clear not flagged");
	// the flag drops once the suspect fetch has been taken
	a_suspect_drops: assert property (
		fetch_suspect_o && fetch_i && !bypass_clr |=> !fetch_suspect_o)
		else $error("suspect flag outlived the third fetch");
	// with the one-shot already selected, a clear does not arm the window
	a_no_rearm: assert property (
		!read_bypass_o && hz_cnt == 2'h0 |=> hz_cnt == 2'h0)
		else $error("hazard window armed without a bypass clear");
	a_sink_no_effect: assert property (
		reg_wr_i && sink_sel && !op_start_i && !op_done_i |=>
			$stable(read_bypass_o) && $stable(key_status))
		else $error("dummy sink write changed state");
	a_unlock_pin: assert property (
		key_open |=> flash_wr_en_o && lock_status_o == 2'h2)
		else $error("unlock not shown on pins");
	// the enable pin and the status pins always tell the same story
	a_pins_agree: assert property (
		flash_wr_en_o == (lock_status_o == FKL_ST_OPEN))
		else $error("write enable and lock status disagree");
	// status pins follow the sequencer one cycle behind
	a_status_lag: assert property (
		lock_status_o != key_status |=>
			lock_status_o == $past(key_status))
		else $error("lock status pins did not follow");
	// a lockout seen on the pins never lifts before reset
	a_dead_sticks: assert property (
		lock_status_o == FKL_ST_DEAD |=>
			lock_status_o == FKL_ST_DEAD && !flash_wr_en_o)
		else $error("lockout lifted without reset");
	// read data stand one cycle only, then return to zero
	a_rdata_idle: assert property (
		!reg_rd_i |=> reg_rdata_o == FKL_RDATA_RST)
		else $error("read data did not return to zero");
	// timing reads show only the bypass bit
	a_timing_readback: assert property (
		reg_rd_i && timing_sel |=>
			reg_rdata_o == {1'b0, $past(read_bypass_o), 6'h00})
		else $error("timing read did not return the bypass bit");
endmodule

`default_nettype wire

// *** inc/fkl_pkg.sv ***
// constants shared by the flash key lock control block
// assumes a byte-wide register port on the system clock
`default_nettype none

package fkl_pkg;
	// register offsets (byte addresses on the register port)
	localparam logic [7:0] FKL_KEY_OFS    = 8'hb6; // flash_key_lock
	localparam logic [7:0] FKL_TIMING_OFS = 8'hb6; // flash_read_timing
	localparam logic [7:0] FKL_SINK_OFS   = 8'he5; // dummy_write_sink
	// page select tells the two registers at the same offset apart
	localparam logic       FKL_KEY_PAGE    = 1'b0;
	localparam logic       FKL_TIMING_PAGE = 1'b1;
	// key values, in the order they must arrive
	localparam logic [7:0] FKL_KEY_FIRST  = 8'ha5;
	localparam logic [7:0] FKL_KEY_SECOND = 8'hf1;
	// field positions and reset values
	localparam int         FKL_BYPASS_BIT   = 6;
	localparam logic       FKL_BYPASS_RST   = 1'b0;
	localparam logic [7:0] FKL_RDATA_RST    = 8'h00;
	// status codes read back from the key register
	localparam logic [1:0] FKL_ST_LOCKED = 2'h0;
	localparam logic [1:0] FKL_ST_FIRST  = 2'h1;
	localparam logic [1:0] FKL_ST_OPEN   = 2'h2;
	localparam logic [1:0] FKL_ST_DEAD   = 2'h3;
	// fetches after a bypass clear; the last one is suspect
	localparam logic [1:0] FKL_HAZ_FETCHES = 2'h3;

	// one-hot key states
	typedef enum logic [3:0] {
		FKL_LOCKED = 4'h1,
		FKL_FIRST  = 4'h2,
		FKL_OPEN   = 4'h4,
		FKL_DEAD   = 4'h8
	} fkl_state_t;
endpackage

`default_nettype wire

// *** verif/fkl_flash_model.sv ***
// flash array model: answers one write/erase request with start, done
// assumes one request at a time, all on the system clock
`default_nettype none

module fkl_flash_model
(
	input  wire logic clk_i,    // system clock
	input  wire logic arst_n_i, // async reset, active low
	input  wire logic go_i,     // bench asks for one write/erase
	output logic      start_o,  // attempt pulse to the lock block
	output logic      done_o    // completion pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cnt; // cycles left in the running operation
	// a few cycles of busy time so the unlocked level can be seen
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			cnt     <= 3'h0;
			start_o <= 1'b0;
			done_o  <= 1'b0;
		end
		else
		begin
			start_o <= go_i;
			done_o  <= (cnt == 3'h1);
			if (go_i)
				cnt <= 3'h4;
			else if (cnt != 3'h0)
				cnt <= cnt - 3'h1;
		end
	end
endmodule

`default_nettype wire

// *** verif/fkl_top_tb.sv ***
// bench for the flash key lock block: key, timing and sink registers
// assumes the flash model drives the operation strobes
`default_nettype none

module fkl_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import fkl_pkg::*;
	logic       clk_i    = 1'b0; // 250 MHz system clock
	logic       arst_n_i = 1'b1; // reset, active low; falls at time 0
	logic [7:0] addr     = 8'h00; // register address
	logic       page     = 1'b0; // page select
	logic [7:0] wd       = 8'h00; // write data
	logic       wr       = 1'b0; // write strobe
	logic       rd       = 1'b0; // read strobe
	logic       go       = 1'b0; // operation request to the model
	logic       fetch    = 1'b0; // opcode fetch pulse
	logic [7:0] rdata;           // read data
	logic       st, dn, wen, byp, sus; // strobes and dut levels
	logic [1:0] lst;             // lock status pins
	int         error_cnt = 0;
	int         n_checks  = 0;

	always #2 clk_i = ~clk_i;

	fkl_flash_model flash (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.go_i(go), .start_o(st), .done_o(dn));
	fkl_top dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .reg_addr_i(addr),
		.reg_page_i(page), .reg_wdata_i(wd), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .op_start_i(st),
		.op_done_i(dn), .fetch_i(fetch), .flash_wr_en_o(wen),
		.lock_status_o(lst), .read_bypass_o(byp),
		.fetch_suspect_o(sus));

	task automatic report_and_stop();
		if (error_cnt == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic p,
		input logic [7:0] d);
		addr <= a;
		page <= p;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
		@(posedge clk_i);
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic p,
		input logic [7:0] e);
		addr <= a;
		page <= p;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1 chk(rdata, e);
		@(posedge clk_i);
	endtask

	task automatic do_reset();
		arst_n_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		arst_n_i <= 1'b1;
		@(posedge clk_i);
	endtask

	task automatic t_reset();
		rd_chk(FKL_KEY_OFS, FKL_KEY_PAGE, 8'h00);
		rd_chk(FKL_TIMING_OFS, FKL_TIMING_PAGE, 8'h00);
		chk({5'h00, sus, wen, byp}, 8'h00);
	endtask

	task automatic t_unlock_op();
		int i;
		wr_reg(FKL_KEY_OFS, FKL_KEY_PAGE, FKL_KEY_FIRST);
		rd_chk(FKL_KEY_OFS, FKL_KEY_PAGE, 8'h01);
		wr_reg(FKL_KEY_OFS, FKL_KEY_PAGE, FKL_KEY_SECOND);
		rd_chk(FKL_KEY_OFS, FKL_KEY_PAGE, 8'h02);
		chk({6'h0, lst}, 8'h02);
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		#1 chk({7'h0, wen}, 8'h01);
		for (i = 0; i < 20 && lst !== FKL_ST_LOCKED; i++)
			@(posedge clk_i);
		if (i == 20)
		begin
			error_cnt++;
			report_and_stop();
		end
		rd_chk(FKL_KEY_OFS, FKL_KEY_PAGE, 8'h00);
		chk({7'h0, wen}, 8'h00);
	endtask

	// sink writes and unmapped reads leave the key sequence alone
	task automatic t_sink();
		wr_reg(FKL_KEY_OFS, FKL_KEY_PAGE, FKL_KEY_FIRST);
		wr_reg(FKL_SINK_OFS, FKL_KEY_PAGE, 8'h77);
		rd_chk(FKL_SINK_OFS, FKL_KEY_PAGE, 8'h00);
		rd_chk(8'h10, FKL_KEY_PAGE, 8'h00);
		rd_chk(FKL_KEY_OFS, FKL_KEY_PAGE, 8'h01);
		wr_reg(FKL_KEY_OFS, FKL_KEY_PAGE, FKL_KEY_SECOND);
		rd_chk(FKL_KEY_OFS, FKL_KEY_PAGE, 8'h02);
		do_reset();
	endtask

	task automatic t_timing();
		wr_reg(FKL_TIMING_OFS, FKL_TIMING_PAGE, 8'h40);
		rd_chk(FKL_TIMING_OFS, FKL_TIMING_PAGE, 8'h40);
		chk({7'h0, byp}, 8'h01);
		rd_chk(FKL_KEY_OFS, FKL_KEY_PAGE, 8'h00);
		wr_reg(FKL_TIMING_OFS, FKL_TIMING_PAGE, 8'h00);
		// the benign sink move that follows the clear fetches two bytes
		fetch <= 1'b1;
		wr_reg(FKL_SINK_OFS, FKL_KEY_PAGE, 8'h5a);
		fetch <= 1'b0;
		@(posedge clk_i);
		#1 chk({6'h0, byp, sus}, 8'h01);
		@(posedge clk_i);
		fetch <= 1'b1;
		@(posedge clk_i);
		fetch <= 1'b0;
		#1 chk({7'h0, sus}, 8'h00);
		@(posedge clk_i);
		rd_chk(FKL_TIMING_OFS, FKL_TIMING_PAGE, 8'h00);
		// a clear while the one-shot is already selected arms nothing
		wr_reg(FKL_TIMING_OFS, FKL_TIMING_PAGE, 8'h00);
		fetch <= 1'b1;
		repeat (3) @(posedge clk_i);
		fetch <= 1'b0;
		#1 chk({7'h0, sus}, 8'h00);
		@(posedge clk_i);
	endtask

	// k is written as a key, or an attempt is made while locked
	task automatic lockout(input logic [7:0] k, input logic op);
		if (op)
			go <= 1'b1;
		else
			wr_reg(FKL_KEY_OFS, FKL_KEY_PAGE, k);
		@(posedge clk_i);
		go <= 1'b0;
		repeat (2) @(posedge clk_i);
		rd_chk(FKL_KEY_OFS, FKL_KEY_PAGE, 8'h03);
		wr_reg(FKL_KEY_OFS, FKL_KEY_PAGE, FKL_KEY_FIRST);
		rd_chk(FKL_KEY_OFS, FKL_KEY_PAGE, 8'h03);
		chk({6'h0, lst}, 8'h03);
		do_reset();
		rd_chk(FKL_KEY_OFS, FKL_KEY_PAGE, 8'h00);
	endtask

	initial
	begin
		do_reset();
		t_reset();
		t_unlock_op();
		t_sink();
		t_timing();
		lockout(8'h33, 1'b0);
		lockout(8'h00, 1'b1);
		wr_reg(FKL_KEY_OFS, FKL_KEY_PAGE, FKL_KEY_FIRST);
		lockout(FKL_KEY_FIRST, 1'b0);
		report_and_stop();
	end
endmodule

`default_nettype wire
